// *** shared/fsu_pkg.sv ***
// Package for the FIFO serial unit: constants, field layouts and state types.
// Assumes a 50 MHz peripheral clock and a 16x base-clock enable from the baud divider.
package fsu_pkg;

    localparam int          FIFO_DEPTH     = 16;
    localparam int          CNT_W          = 5;
    localparam int          OVS_RATIO      = 16;
    localparam logic [3:0]  SAMPLE_TICK    = 4'h7;
    localparam logic [3:0]  LAST_TICK      = 4'hF;
    localparam logic [3:0]  DATA_BITS      = 4'h8;
    localparam int          CLK_MHZ        = 50;
    localparam int          DMA_GAP_CYCLES = 5;
    localparam logic [15:0] BAUD_DIV_RST   = 16'h001B;
    localparam logic [1:0]  TRG_SEL_RST    = 2'h0;
    localparam int          CNT_RX_LSB     = 0;
    localparam int          CNT_TX_LSB     = 8;

    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } fsu_rx_state_t;

    typedef enum logic [1:0]
    {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b10,
        TX_STOP  = 2'b11
    } fsu_tx_state_t;

    typedef struct packed
    {
        logic [1:0] tx_trg;
        logic [1:0] rx_trg;
    } fsu_fifo_ctrl_t;

    typedef struct packed
    {
        logic tx_pin_direction;
        logic tx_pin_level;
    } fsu_port_pin_t;

endpackage : fsu_pkg

// *** rtl/fsu_core.sv ***
// FIFO serial unit core: 16-byte TX and RX FIFOs, threshold flags, async
// receiver with break handling, transmitter with port-pin override.
// Assumes CPU-side strobes are on I_CLK and the RX pin is asynchronous.
`timescale 1ns/1ns
`default_nettype none
module fsu_core
    import fsu_pkg::*;
(
    // Clock, reset, enable
    input  wire logic           I_CLK,
    input  wire logic           I_SYS_RST,
    input  wire logic           I_CE,
    // Configuration
    input  wire fsu_fifo_ctrl_t I_FIFO_CTRL,
    input  wire fsu_port_pin_t  I_PORT_PIN,
    input  wire logic           I_TRANSMIT_ENABLE,
    input  wire logic           I_RECEIVE_ENABLE,
    input  wire logic           I_PARITY_EN,
    input  wire logic           I_PARITY_ODD,
    input  wire logic [15:0]    I_BAUD_DIV,
    // Transmit FIFO write port
    input  wire logic           I_TX_WR,
    input  wire logic [7:0]     I_TX_DATA,
    output logic                O_TX_READY,
    // Receive FIFO read port
    input  wire logic           I_RX_RD,
    output logic [7:0]          O_RX_DATA,
    output logic                O_RX_VALID,
    // Status flags and clears
    input  wire logic           I_TX_EMPTY_CLR,
    input  wire logic           I_RX_FULL_CLR,
    input  wire logic           I_ERR_CLR,
    input  wire logic           I_TX_DONE_CLR,
    output logic                O_TX_FIFO_EMPTY_FLAG,
    output logic                O_RX_FIFO_FULL_FLAG,
    output logic                O_FRAME_ERROR_FLAG,
    output logic                O_PARITY_ERROR_FLAG,
    output logic                O_TX_DONE_FLAG,
    output logic                O_BREAK_ACTIVE,
    output logic [15:0]         O_FIFO_COUNT_REG,
    // Serial pins
    input  wire logic           I_RXD,
    output logic                O_TXD,
    output logic                O_TXD_OE
);

    function automatic logic [CNT_W-1:0] trg_tx(input logic [1:0] sel);
        case (sel)
            2'h0:    trg_tx = 5'h08;
            2'h1:    trg_tx = 5'h04;
            2'h2:    trg_tx = 5'h02;
            default: trg_tx = 5'h01;
        endcase
    endfunction : trg_tx

    function automatic logic [CNT_W-1:0] trg_rx(input logic [1:0] sel);
        case (sel)
            2'h0:    trg_rx = 5'h01;
            2'h1:    trg_rx = 5'h04;
            2'h2:    trg_rx = 5'h08;
            default: trg_rx = 5'h0E;
        endcase
    endfunction : trg_rx

    // Base clock enable at 16x the bit rate
    logic [15:0] baud_cnt_q;
    logic        tick;
    assign tick = I_CE && (baud_cnt_q == 16'h0000);
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            baud_cnt_q <= 16'h0000;
        else if (I_CE)
            baud_cnt_q <= (baud_cnt_q == 16'h0000) ? I_BAUD_DIV : baud_cnt_q - 16'h0001;
    end

    // Transmit FIFO
    logic [7:0]       tx_mem [FIFO_DEPTH];
    logic [3:0]       tx_wp_q, tx_rp_q;
    logic [CNT_W-1:0] tx_cnt_q;
    logic             tx_push, tx_pop;
    assign O_TX_READY = (tx_cnt_q != 5'h10);
    assign tx_push    = I_CE && I_TX_WR && O_TX_READY;
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            tx_wp_q  <= 4'h0;
            tx_rp_q  <= 4'h0;
            tx_cnt_q <= 5'h00;
        end
        else if (I_CE)
        begin
            if (tx_push)
            begin
                tx_mem[tx_wp_q] <= I_TX_DATA;
                tx_wp_q         <= tx_wp_q + 4'h1;
            end
            if (tx_pop)
                tx_rp_q <= tx_rp_q + 4'h1;
            tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
        end
    end

    // Receive FIFO
    logic [7:0]       rx_mem [FIFO_DEPTH];
    logic [3:0]       rx_wp_q, rx_rp_q;
    logic [CNT_W-1:0] rx_cnt_q;
    logic             rx_push, rx_pop;
    logic [7:0]       rx_shift_q;
    assign O_RX_VALID = (rx_cnt_q != 5'h00);
    assign rx_pop     = I_CE && I_RX_RD && O_RX_VALID;
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            rx_wp_q   <= 4'h0;
            rx_rp_q   <= 4'h0;
            rx_cnt_q  <= 5'h00;
            O_RX_DATA <= 8'h00;
        end
        else if (I_CE)
        begin
            if (rx_push)
            begin
                rx_mem[rx_wp_q] <= rx_shift_q;
                rx_wp_q         <= rx_wp_q + 4'h1;
            end
            if (rx_pop)
                rx_rp_q <= rx_rp_q + 4'h1;
            rx_cnt_q  <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
            O_RX_DATA <= rx_mem[rx_pop ? rx_rp_q + 4'h1 : rx_rp_q];
        end
    end

    // Count register: TX high byte, RX low byte
    assign O_FIFO_COUNT_REG = {3'h0, tx_cnt_q, 3'h0, rx_cnt_q};

    // Threshold flags; hardware set wins over software clear
    logic tx_below, rx_at;
    assign tx_below = tx_cnt_q < trg_tx(I_FIFO_CTRL.tx_trg);
    assign rx_at    = rx_cnt_q >= trg_rx(I_FIFO_CTRL.rx_trg);
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            O_TX_FIFO_EMPTY_FLAG <= 1'b1;
            O_RX_FIFO_FULL_FLAG  <= 1'b0;
        end
        else if (I_CE)
        begin
            // A clear at trigger sets the flag (flag OR clear) and below trigger the flag is forced set
            if (tx_below || tx_cnt_q <= trg_tx(I_FIFO_CTRL.tx_trg))
                O_TX_FIFO_EMPTY_FLAG <= tx_below ? 1'b1 : (O_TX_FIFO_EMPTY_FLAG | 1'b0) & ~I_TX_EMPTY_CLR | I_TX_EMPTY_CLR;
            else if (I_TX_EMPTY_CLR)
                O_TX_FIFO_EMPTY_FLAG <= 1'b0;
            if (rx_at)
                O_RX_FIFO_FULL_FLAG <= 1'b1;
            else if (I_RX_FULL_CLR)
                O_RX_FIFO_FULL_FLAG <= 1'b0;
        end
    end

    // Receive pin synchroniser
    logic rxd_m_q, rxd_s_q;
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            rxd_m_q <= 1'b1;
            rxd_s_q <= 1'b1;
        end
        else if (I_CE)
        begin
            rxd_m_q <= I_RXD;
            rxd_s_q <= rxd_m_q;
        end
    end

    // Asynchronous receiver
    fsu_rx_state_t rx_st_q;
    logic [3:0]    rx_ph_q, rx_bit_q;
    logic          rx_par_q, rx_zero_q, rx_samp;
    assign rx_samp = tick && (rx_ph_q == SAMPLE_TICK);
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST || !I_RECEIVE_ENABLE)
        begin
            rx_st_q    <= RX_IDLE;
            rx_ph_q    <= 4'h0;
            rx_bit_q   <= 4'h0;
            rx_shift_q <= 8'h00;
            rx_par_q   <= 1'b0;
            rx_zero_q  <= 1'b1;
        end
        else if (tick)
        begin
            rx_ph_q <= rx_ph_q + 4'h1;
            case (rx_st_q)
                RX_IDLE:
                begin
                    rx_ph_q <= 4'h0;
                    if (!rxd_s_q)
                        rx_st_q <= RX_START;
                end
                RX_START:
                    if (rx_samp)
                    begin
                        rx_st_q   <= rxd_s_q ? RX_IDLE : RX_DATA;
                        rx_bit_q  <= 4'h0;
                        rx_par_q  <= I_PARITY_ODD;
                        rx_zero_q <= 1'b1;
                    end
                RX_DATA:
                    if (rx_samp)
                    begin
                        rx_bit_q  <= rx_bit_q + 4'h1;
                        rx_par_q  <= rx_par_q ^ rxd_s_q;
                        rx_zero_q <= rx_zero_q & ~rxd_s_q;
                        if (rx_bit_q < DATA_BITS)
                            rx_shift_q <= {rxd_s_q, rx_shift_q[7:1]};
                        if (rx_bit_q == DATA_BITS - {3'h0, ~I_PARITY_EN})
                            rx_st_q <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_samp)
                        rx_st_q <= RX_IDLE;
                default:
                    rx_st_q <= RX_IDLE;
            endcase
        end
    end

    logic stop_samp, frame_bad, break_seen;
    assign stop_samp  = rx_samp && (rx_st_q == RX_STOP);
    assign frame_bad  = stop_samp && !rxd_s_q;
    assign break_seen = frame_bad && rx_zero_q;
    assign rx_push    = stop_samp && !frame_bad && (rx_cnt_q != 5'h10);

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            O_FRAME_ERROR_FLAG  <= 1'b0;
            O_PARITY_ERROR_FLAG <= 1'b0;
            O_BREAK_ACTIVE      <= 1'b0;
        end
        else if (I_CE)
        begin
            if (frame_bad)
                O_FRAME_ERROR_FLAG <= 1'b1;
            else if (I_ERR_CLR)
                O_FRAME_ERROR_FLAG <= 1'b0;
            if (stop_samp && I_PARITY_EN && rx_par_q)
                O_PARITY_ERROR_FLAG <= 1'b1;
            else if (I_ERR_CLR)
                O_PARITY_ERROR_FLAG <= 1'b0;
            if (break_seen)
                O_BREAK_ACTIVE <= 1'b1;
            else if (rxd_s_q)
                O_BREAK_ACTIVE <= 1'b0;
        end
    end

    // Transmitter; cleared whole the moment transmit enable drops
    fsu_tx_state_t tx_st_q;
    logic [3:0]    tx_ph_q, tx_bit_q;
    logic [7:0]    tx_sh_q;
    logic          tx_par_q, tx_line_q, tx_bit_end;
    assign tx_bit_end = tick && (tx_ph_q == LAST_TICK);
    assign tx_pop     = I_CE && I_TRANSMIT_ENABLE && (tx_st_q == TX_IDLE) && (tx_cnt_q != 5'h00);
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST || !I_TRANSMIT_ENABLE)
        begin
            tx_st_q   <= TX_IDLE;
            tx_ph_q   <= 4'h0;
            tx_bit_q  <= 4'h0;
            tx_sh_q   <= 8'h00;
            tx_par_q  <= 1'b0;
            tx_line_q <= 1'b1;
        end
        else if (I_CE)
        begin
            if (tick)
                tx_ph_q <= tx_ph_q + 4'h1;
            case (tx_st_q)
                TX_IDLE:
                    if (tx_pop)
                    begin
                        tx_sh_q   <= tx_mem[tx_rp_q];
                        tx_par_q  <= I_PARITY_ODD;
                        tx_ph_q   <= 4'h0;
                        tx_line_q <= 1'b0;
                        tx_st_q   <= TX_START;
                    end
                TX_START:
                    if (tx_bit_end)
                    begin
                        tx_bit_q  <= 4'h0;
                        tx_line_q <= tx_sh_q[0];
                        tx_st_q   <= TX_DATA;
                    end
                TX_DATA:
                    if (tx_bit_end)
                    begin
                        tx_bit_q <= tx_bit_q + 4'h1;
                        tx_par_q <= tx_par_q ^ tx_line_q;
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        if (tx_bit_q == DATA_BITS - 4'h1 && I_PARITY_EN)
                            tx_line_q <= tx_par_q ^ tx_line_q;
                        else if (tx_bit_q >= DATA_BITS - 4'h1)
                        begin
                            tx_line_q <= 1'b1;
                            tx_st_q   <= TX_STOP;
                        end
                        else
                            tx_line_q <= tx_sh_q[1];
                    end
                TX_STOP:
                    if (tx_bit_end)
                        tx_st_q <= TX_IDLE;
                default:
                    tx_st_q <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            O_TX_DONE_FLAG <= 1'b1;
        else if (I_CE)
        begin
            if (tx_st_q == TX_STOP && tx_bit_end && tx_cnt_q == 5'h00)
                O_TX_DONE_FLAG <= 1'b1;
            else if (I_TX_DONE_CLR || tx_push)
                O_TX_DONE_FLAG <= 1'b0;
        end
    end

    // Port pin bits own the line while transmit is disabled
    assign O_TXD    = I_TRANSMIT_ENABLE ? tx_line_q : I_PORT_PIN.tx_pin_level;
    assign O_TXD_OE = I_TRANSMIT_ENABLE | I_PORT_PIN.tx_pin_direction;

    a_tx_flag_set: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_CE && tx_below |=> O_TX_FIFO_EMPTY_FLAG)
        else $error("tx empty flag missed");
    a_rx_flag_set: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_CE && rx_at && I_RX_FULL_CLR |=> O_RX_FIFO_FULL_FLAG)
        else $error("rx full flag lost to clear");
    a_count_field: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_CE && tx_push && !tx_pop |=> O_FIFO_COUNT_REG[12:8] == $past(tx_cnt_q) + 5'h01)
        else $error("tx count wrong");
    a_rx_count: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_CE && rx_pop && !rx_push |=> O_FIFO_COUNT_REG[4:0] == $past(rx_cnt_q) - 5'h01)
        else $error("rx count wrong");
    a_break_noload: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        frame_bad |-> !rx_push ##1 O_FRAME_ERROR_FLAG)
        else $error("break byte stored");
    a_pin_idle: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !I_TRANSMIT_ENABLE
        |-> O_TXD == I_PORT_PIN.tx_pin_level && O_TXD_OE == I_PORT_PIN.tx_pin_direction)
        else $error("pin level not followed");
    a_tx_reset: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        $fell(I_TRANSMIT_ENABLE) |=> tx_st_q == TX_IDLE)
        else $error("transmitter not reset");
    a_sample_pt: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        rx_st_q == RX_IDLE && tick && !rxd_s_q && I_RECEIVE_ENABLE
        |=> rx_st_q == RX_START && rx_ph_q == 4'h0)
        else $error("start sync wrong");
    c_tx_frame: cover property (@(posedge I_CLK) tx_st_q == TX_STOP ##1 tx_st_q == TX_IDLE);
    c_rx_push: cover property (@(posedge I_CLK) rx_push);
    c_break: cover property (@(posedge I_CLK) break_seen);

endmodule : fsu_core
`default_nettype wire

// *** dv/fsu_remote.sv ***
// Remote asynchronous transceiver model: drives the receive pin, decodes the transmit pin.
// Assumes 8N1 frames, LSB first, BIT_CLKS clocks of the shared clock per bit.
`timescale 1ns/1ns
`default_nettype none
module fsu_remote #(
    parameter int BIT_CLKS = 32
) (
    // Clock
    input  wire logic clk,
    // Serial pins and monitor enable
    input  wire logic i_txd,
    input  wire logic i_listen,
    output var logic  o_rxd
);
    logic [7:0] rx_q [$];
    logic [7:0] mon_v;

    initial o_rxd = 1'b1;

    // Inverse shown for skew clocks at a bit start when skew is nonzero, so an early sampler is caught
    task automatic drive_bit(input logic v, input int skew);
        @(posedge clk);
        if (skew > 0)
        begin
            o_rxd <= ~v;
            repeat (skew) @(posedge clk);
        end
        o_rxd <= v;
        repeat (BIT_CLKS - 1 - skew) @(posedge clk);
    endtask : drive_bit

    task automatic send_byte(input logic [7:0] b, input int skew);
        drive_bit(1'b0, 0);
        for (int i = 0; i < 8; i++)
            drive_bit(b[i], skew);
        drive_bit(1'b1, 0);
    endtask : send_byte

    // Ends by driving one mark bit, so the line rests at mark once the break ends
    task automatic send_break(input int n_bits);
        for (int i = 0; i < n_bits; i++)
            drive_bit(1'b0, 0);
        drive_bit(1'b1, 0);
    endtask : send_break

    // Listens only and never clocks the link; a FIFO write with transmit enabled starts the frame it decodes
    always @(negedge i_txd)
        if (i_listen)
        begin
            repeat (BIT_CLKS / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CLKS) @(posedge clk);
                mon_v[i] = i_txd;
            end
            rx_q.push_back(mon_v);
        end
endmodule : fsu_remote
`default_nettype wire

// *** dv/tb_top.sv ***
// Testbench for fsu_core: CPU-side strobes plus a remote transceiver on the pins.
// Assumes one 50 MHz clock and a base tick every two clocks (32 clocks a bit).
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import fsu_pkg::*;
;
    localparam logic [15:0] DIV      = 16'h0001;
    localparam int          BIT_CLKS = OVS_RATIO * 2;

    logic           clk = 1'b0;
    logic           rst, te, re, tx_wr, rx_rd, txe_clr, rxf_clr, err_clr, listen;
    logic           rdy, rx_valid, txe_f, rxf_f, fe_f, pe_f, done_f, brk, txd, txd_oe, rxd;
    logic [7:0]     tx_data, rx_data;
    logic [15:0]    cnt;
    fsu_fifo_ctrl_t fctl;
    fsu_port_pin_t  ppin;
    int             err_total = 0;
    int             n_checks  = 0;
    int             rtrg [4]  = '{1, 4, 8, 14};
    int             k, trg;

    always #10 clk = ~clk;

    fsu_core fsu_core_inst (
        .I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_FIFO_CTRL(fctl), .I_PORT_PIN(ppin),
        .I_TRANSMIT_ENABLE(te), .I_RECEIVE_ENABLE(re), .I_PARITY_EN(1'b0),
        .I_PARITY_ODD(1'b0), .I_BAUD_DIV(DIV), .I_TX_WR(tx_wr), .I_TX_DATA(tx_data),
        .O_TX_READY(rdy), .I_RX_RD(rx_rd), .O_RX_DATA(rx_data), .O_RX_VALID(rx_valid),
        .I_TX_EMPTY_CLR(txe_clr), .I_RX_FULL_CLR(rxf_clr), .I_ERR_CLR(err_clr),
        .I_TX_DONE_CLR(1'b0), .O_TX_FIFO_EMPTY_FLAG(txe_f), .O_RX_FIFO_FULL_FLAG(rxf_f),
        .O_FRAME_ERROR_FLAG(fe_f), .O_PARITY_ERROR_FLAG(pe_f), .O_TX_DONE_FLAG(done_f),
        .O_BREAK_ACTIVE(brk), .O_FIFO_COUNT_REG(cnt), .I_RXD(rxd), .O_TXD(txd),
        .O_TXD_OE(txd_oe)
    );

    fsu_remote #(.BIT_CLKS(BIT_CLKS)) fsu_remote_inst (
        .clk(clk), .i_txd(txd), .i_listen(listen), .o_rxd(rxd)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, err_total);
    endtask : end_test

    function automatic logic [7:0] pat(input int s, input int i);
        return 8'(8'hA5 ^ (s * 16 + i * 7));
    endfunction : pat

    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic do_reset();
        @(posedge clk) rst <= 1'b1;
        // Transmit held off so the next fill is not drained at once
        te <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic push(input logic [7:0] b);
        @(posedge clk) tx_wr <= 1'b1;
        tx_data <= b;
        @(posedge clk) tx_wr <= 1'b0;
    endtask : push

    task automatic pop();
        @(posedge clk) rx_rd <= 1'b1;
        @(posedge clk) rx_rd <= 1'b0;
    endtask : pop

    // Bit 0 clears the transmit flag, bit 1 the receive flag, bit 2 the errors
    task automatic clr(input logic [2:0] m);
        @(posedge clk) {err_clr, rxf_clr, txe_clr} <= m;
        @(posedge clk) {err_clr, rxf_clr, txe_clr} <= 3'h0;
    endtask : clr

    initial
    begin
        {rst, te, re, tx_wr, rx_rd, txe_clr, rxf_clr, err_clr, listen} = 9'h100;
        tx_data = 8'h00;
        fctl    = '0;
        ppin    = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(cnt, 16'h0000, "counts after reset");
        chk(txe_f, 16'h0001, "empty flag after reset");
        for (int p = 0; p < 4; p++)
        begin
            @(posedge clk) ppin <= fsu_port_pin_t'(p[1:0]);
            settle();
            chk({txd_oe, txd}, 16'(p), "pin follows port bits");
        end
        end_test("pin override");
        for (int i = 0; i < FIFO_DEPTH + 1; i++)
            push(8'(i));
        settle();
        chk(cnt, 16'h1000, "tx count at full");
        chk(rdy, 16'h0000, "ready low at full");
        end_test("tx fifo full");
        // Port bits left at direction 1, level 1 before transmit is enabled
        for (int s = 0; s < 4; s++)
        begin
            trg = 8 >> s;
            do_reset();
            fctl.tx_trg <= 2'(s);
            for (int i = 0; i < trg; i++)
                push(pat(s, i));
            settle();
            chk(cnt, 16'(trg) << 8, "tx count");
            chk(done_f, 16'h0000, "done flag cleared by write");
            clr(3'h1);
            settle();
            chk(txe_f, 16'h0001, "empty flag sets again");
            push(pat(s, trg));
            clr(3'h1);
            settle();
            chk(txe_f, 16'h0000, "empty flag cleared above trigger");
            @(posedge clk) te <= 1'b1;
            listen <= 1'b1;
            for (k = 0; k < 20000 && txe_f !== 1'b1; k++)
                @(negedge clk);
            chk(16'(k < 20000 && cnt[12:8] < 5'(trg)), 16'h0001, "flag set below trigger");
            for (k = 0; k < 20000 && fsu_remote_inst.rx_q.size() < trg + 1; k++)
                @(posedge clk);
            if (k == 20000)
            begin
                err_total++;
                $display("CHECK FAILED t=%0t no serial output", $time);
                close_out();
            end
            // Plain CPU writes, no DMA, so the done flag is defined here
            repeat (2 * BIT_CLKS) @(posedge clk);
            chk(done_f, 16'h0001, "done flag after last stop bit");
            for (int i = 0; i <= trg; i++)
                chk(fsu_remote_inst.rx_q[i], pat(s, i), "serial byte");
            fsu_remote_inst.rx_q.delete();
        end
        end_test("tx thresholds");
        @(posedge clk) listen <= 1'b0;
        push(8'h00);
        repeat (3 * BIT_CLKS) @(posedge clk);
        ppin.tx_pin_level <= 1'b0;
        @(posedge clk) te <= 1'b0;
        settle();
        chk({txd_oe, txd}, 16'h0002, "break driven low");
        repeat (BIT_CLKS) @(posedge clk);
        chk({txd_oe, txd}, 16'h0002, "break held low");
        end_test("send break");
        @(posedge clk) re <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            do_reset();
            fctl.rx_trg <= 2'(s);
            for (int i = 0; i < rtrg[s]; i++)
            begin
                settle();
                chk(cnt, 16'(i), "rx count");
                chk(rxf_f, 16'h0000, "full flag below trigger");
                fsu_remote_inst.send_byte(pat(s, i), 6);
            end
            settle();
            chk(cnt, 16'(rtrg[s]), "rx count at trigger");
            chk(rxf_f, 16'h0001, "full flag at trigger");
            chk(rx_valid, 16'h0001, "data valid at trigger");
            clr(3'h2);
            settle();
            chk(rxf_f, 16'h0001, "full flag sets again");
            for (int i = 0; i < rtrg[s]; i++)
            begin
                chk(rx_data, pat(s, i), "rx byte");
                pop();
                settle();
            end
            clr(3'h2);
            settle();
            chk(rxf_f, 16'h0000, "full flag cleared when drained");
            chk(rx_valid, 16'h0000, "valid low when drained");
        end
        end_test("rx thresholds");
        // One whole frame of zeros: the restart after it ends as a false start
        fork
            fsu_remote_inst.send_break(10);
            begin
                repeat (10 * BIT_CLKS) @(posedge clk);
                chk(brk, 16'h0001, "break seen while line low");
            end
        join
        settle();
        chk(fe_f, 16'h0001, "frame error on break");
        chk(pe_f, 16'h0000, "no parity error with parity off");
        chk(cnt, 16'h0000, "break not stored");
        chk(brk, 16'h0000, "break ends on mark");
        clr(3'h4);
        fsu_remote_inst.send_byte(8'h3C, 0);
        settle();
        chk(fe_f, 16'h0000, "frame error cleared");
        chk(cnt, 16'h0001, "receiver runs after break");
        chk(rx_data, 16'h003C, "byte after break");
        end_test("rx break");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
